// >>> rtl/bdl_device.sv
// Function
// - host waits 36 bus clocks after firmware write
// - host waits 76 bus clocks after step/go
// - prefer acknowledge over fixed delays
// - command byte is eight falling-edge bit times
// - pin is mode input while in reset
// - bit timing from selected target clock
// - host falling edge opens every bit
// - msb first, sixteen target clocks per bit
// - timeout after 512 clocks without edge
// - highs pulled; speedup pulses drive high briefly
// - resync on each edge, delays from there
// - sample host bit ten ticks after start
// - host one must rise by tick eight
// - host holds low at least two ticks
// - returning one: speedup at tick seven
// - host samples returned bit near tick ten
// - returning zero: low thirteen ticks, then speedup
// - opcode, then address/data words, reads sixteen bits
// - acknowledge: sixteen-tick low, then speedup
module bdl_device
    import bdl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    bdl_link_if.device link,
    input wire logic serial_clock_select_i,
    output logic mode_select_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [BDL_FIFO_WIDTH-1:0] rx_data_o,
    output logic rx_is_opcode_o,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [BDL_FIFO_WIDTH-1:0] tx_data_i,
    input wire logic ack_req_i,
    output logic ack_busy_o,
    output logic timeout_o
);
    typedef enum logic [2:0] {BDL_IDLE, BDL_RX, BDL_TX, BDL_ACK, BDL_WAIT} bdl_dstate_t;
    bdl_dstate_t st_r, st_nxt;
    logic s1_r, s2_r, s3_r;
    logic [3:0] div_r, div_nxt;
    logic tick;
    logic [4:0] tk_r, tk_nxt;
    logic [9:0] to_r, to_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [4:0] nb_r, nb_nxt;
    logic first_r, first_nxt;
    logic oe_r, oe_nxt, do_r, do_nxt;
    logic to_flag_r, to_flag_nxt;
    logic push, fin_valid, fin_ready, fout_valid;
    logic [15:0] fout_data;
    logic fall;
    logic tx_bit_r, tx_bit_nxt;
    logic [15:0] txw_r, txw_nxt;
    logic [4:0] txn_r, txn_nxt;
    logic txload;

    // first flop only feeds the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
        end else begin
            s1_r <= link.debug_serial_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_comb begin
        fall = s3_r && !s2_r && !oe_r;
        tick = div_r == '0;
        // target clock chosen by the select input
        div_nxt = tick ? 4'(serial_clock_select_i ? BDL_FAST_DIV - 1 : BDL_SLOW_DIV - 1)
                       : div_r - 1'b1;
        st_nxt = st_r;
        tk_nxt = tk_r;
        to_nxt = to_r;
        sh_nxt = sh_r;
        nb_nxt = nb_r;
        first_nxt = first_r;
        oe_nxt = 1'b0;
        do_nxt = 1'b1;
        to_flag_nxt = 1'b0;
        push = 1'b0;
        txload = 1'b0;
        tx_bit_nxt = tx_bit_r;
        txw_nxt = txw_r;
        txn_nxt = txn_r;
        if (txn_r == '0 && fout_valid) begin
            txload = 1'b1;
            txw_nxt = fout_data;
            txn_nxt = 5'(BDL_WORD_BITS);
        end
        if (tick && st_r != BDL_IDLE) begin
            tk_nxt = tk_r + 1'b1;
        end
        if (fall) begin
            to_nxt = '0;
        end else if (tick && to_r != 10'(BDL_TIMEOUT_TICKS)) begin
            to_nxt = to_r + 1'b1;
        end
        unique case (st_r)
            BDL_IDLE: begin
                if (ack_req_i) begin
                    st_nxt = BDL_ACK;
                    tk_nxt = '0;
                end else if (fall) begin
                    tk_nxt = '0;
                    st_nxt = txn_r != '0 ? BDL_TX : BDL_RX;
                    tx_bit_nxt = txw_r[15];
                end
            end
            BDL_RX: begin
                if (tick && tk_r == 5'(BDL_SAMPLE_TICK - 1)) begin
                    sh_nxt = {sh_r[14:0], s2_r};
                    nb_nxt = nb_r + 1'b1;
                    if (first_r && nb_r == 5'(BDL_OPCODE_BITS - 1)) begin
                        push = 1'b1;
                        first_nxt = 1'b0;
                        nb_nxt = '0;
                    end else if (!first_r && nb_r == 5'(BDL_WORD_BITS - 1)) begin
                        push = 1'b1;
                        nb_nxt = '0;
                    end
                    st_nxt = BDL_WAIT;
                end
            end
            BDL_TX: begin
                if (!tx_bit_r && tk_r < 5'(BDL_ZERO_LOW_TICKS)) begin
                    oe_nxt = 1'b1;
                    do_nxt = 1'b0;
                end else if (!tx_bit_r && tk_r == 5'(BDL_ZERO_LOW_TICKS)) begin
                    oe_nxt = 1'b1;
                end else if (tx_bit_r && tk_r == 5'(BDL_ONE_SPEEDUP_TICK)) begin
                    oe_nxt = 1'b1;
                end
                if (tick && tk_r == 5'(BDL_ZERO_LOW_TICKS)) begin
                    txw_nxt = {txw_r[14:0], 1'b0};
                    txn_nxt = txn_r - 1'b1;
                    st_nxt = BDL_WAIT;
                end
            end
            BDL_ACK: begin
                if (tk_r < 5'(BDL_ACK_LOW_TICKS)) begin
                    oe_nxt = 1'b1;
                    do_nxt = 1'b0;
                end else if (tk_r == 5'(BDL_ACK_LOW_TICKS)) begin
                    oe_nxt = 1'b1;
                end
                if (tick && tk_r == 5'(BDL_ACK_LOW_TICKS)) begin
                    st_nxt = BDL_IDLE;
                end
            end
            BDL_WAIT: begin
                if (tick && tk_r == 5'(BDL_BIT_TICKS - 2)) begin
                    st_nxt = BDL_IDLE;
                end
            end
            default: st_nxt = BDL_IDLE;
        endcase
        if (tick && to_r == 10'(BDL_TIMEOUT_TICKS - 1) && !fall
            && (nb_r != '0 || !first_r)) begin
            to_flag_nxt = 1'b1;
            nb_nxt = '0;
            first_nxt = 1'b1;
            sh_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= BDL_IDLE;
            div_r <= '0;
            tk_r <= '0;
            to_r <= '0;
            sh_r <= '0;
            nb_r <= '0;
            first_r <= 1'b1;
            oe_r <= 1'b0;
            do_r <= 1'b1;
            to_flag_r <= 1'b0;
            tx_bit_r <= 1'b0;
            txw_r <= '0;
            txn_r <= '0;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            tk_r <= tk_nxt;
            to_r <= to_nxt;
            sh_r <= sh_nxt;
            nb_r <= nb_nxt;
            first_r <= first_nxt;
            oe_r <= oe_nxt;
            do_r <= do_nxt;
            to_flag_r <= to_flag_nxt;
            tx_bit_r <= tx_bit_nxt;
            txw_r <= txw_nxt;
            txn_r <= txn_nxt;
        end
    end

    // mode strap caught on the first clocked edge after release
    logic strap_done_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
        end
    end
    // strap pair has no reset so it keeps sampling the pin during reset
    logic strap1_r, strap2_r;
    always_ff @(posedge clk_i) begin
        strap1_r <= link.debug_serial_pin;
        strap2_r <= strap1_r;
        if (!strap_done_r) begin
            mode_select_o <= strap2_r;
        end
    end

    logic op_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_r <= 1'b0;
        end else if (push) begin
            op_r <= first_r;
        end
    end

    bdl_fifo #(.WIDTH(BDL_FIFO_WIDTH), .DEPTH(BDL_FIFO_DEPTH)) u_rx (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(push),
        .in_ready_o(fin_ready),
        .in_data_i({sh_r[14:0], s2_r}),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );
    bdl_fifo #(.WIDTH(BDL_FIFO_WIDTH), .DEPTH(BDL_FIFO_DEPTH)) u_tx (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(fout_valid),
        .out_ready_i(txload),
        .out_data_o(fout_data)
    );
    assign fin_valid = push;
    assign rx_is_opcode_o = op_r;
    assign link.dev_oe = oe_r;
    assign link.dev_o = do_r;
    assign ack_busy_o = st_r == BDL_ACK;
    assign timeout_o = to_flag_r;
endmodule // bdl_device

// >>> rtl/bdl_pkg.sv
package bdl_pkg;
    // target clock: one serial tick is one enable pulse from a divider
    localparam int BDL_BIT_TICKS = 16;
    localparam int BDL_SAMPLE_TICK = 10;
    localparam int BDL_ONE_SPEEDUP_TICK = 7;
    localparam int BDL_ZERO_LOW_TICKS = 13;
    localparam int BDL_GLITCH_TICK = 8;
    localparam int BDL_HOST_LOW_TICKS = 2;
    localparam int BDL_HOST_ONE_LOW_TICKS = 4;
    localparam int BDL_HOST_ZERO_LOW_TICKS = 13;
    localparam int BDL_SPEEDUP_TICKS = 1;
    localparam int BDL_TIMEOUT_TICKS = 512;
    localparam int BDL_ACK_LOW_TICKS = 16;
    localparam int BDL_OPCODE_BITS = 8;
    localparam int BDL_WORD_BITS = 16;
    localparam int BDL_FW_WRITE_WAIT_BUS = 36;
    localparam int BDL_STEP_GO_WAIT_BUS = 76;
    localparam int BDL_CLK_HZ = 125000000;
    localparam int BDL_FAST_DIV = 2;
    localparam int BDL_SLOW_DIV = 8;
    localparam int BDL_FIFO_WIDTH = 16;
    localparam int BDL_FIFO_DEPTH = 16;
    localparam logic BDL_SEL_RESET = 1'b0;
    localparam logic BDL_MODE_RESET = 1'b1;
endpackage

// >>> rtl/bdl_link_if.sv
interface bdl_link_if;
    logic dev_oe;
    logic dev_o;
    logic host_oe;
    logic host_o;
    logic debug_serial_pin;
    // pseudo open drain: pull-up when nobody drives, low wins a conflict
    assign debug_serial_pin = (dev_oe && !dev_o) || (host_oe && !host_o) ? 1'b0 : 1'b1;
    modport device (output dev_oe, output dev_o, input debug_serial_pin);
    modport host (output host_oe, output host_o, input debug_serial_pin);
endinterface

// >>> rtl/bdl_fifo.sv
module bdl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;
    always_comb begin
        in_ready_o = cnt_r != (AW+1)'(DEPTH);
        out_valid_o = cnt_r != '0;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        out_data_o = mem_r[rp_r];
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
endmodule // bdl_fifo

// >>> rtl/bdl_host.sv
module bdl_host
    import bdl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    bdl_link_if.host link,
    input wire logic serial_clock_select_i,
    input wire logic bit_start_i,
    input wire logic bit_write_i,
    input wire logic bit_val_i,
    output logic bit_ready_o,
    output logic bit_done_o,
    output logic bit_rx_o
);
    typedef enum logic [1:0] {BDH_IDLE, BDH_BIT} bdl_hstate_t;
    bdl_hstate_t st_r, st_nxt;
    logic s1_r, s2_r;
    logic [3:0] div_r, div_nxt;
    logic tick;
    logic [4:0] tk_r, tk_nxt;
    logic wr_r, wr_nxt, v_r, v_nxt;
    logic oe_r, oe_nxt, o_r, o_nxt;
    logic rx_r, rx_nxt, done_r, done_nxt;
    always_comb begin
        tick = div_r == '0;
        div_nxt = tick ? 4'(serial_clock_select_i ? BDL_FAST_DIV - 1 : BDL_SLOW_DIV - 1)
                       : div_r - 1'b1;
        st_nxt = st_r;
        tk_nxt = tk_r;
        wr_nxt = wr_r;
        v_nxt = v_r;
        oe_nxt = 1'b0;
        o_nxt = 1'b1;
        rx_nxt = rx_r;
        done_nxt = 1'b0;
        unique case (st_r)
            BDH_IDLE: begin
                if (bit_start_i && tick) begin
                    st_nxt = BDH_BIT;
                    tk_nxt = '0;
                    wr_nxt = bit_write_i;
                    v_nxt = bit_val_i;
                    oe_nxt = 1'b1;
                    o_nxt = 1'b0;
                end
            end
            BDH_BIT: begin
                if (wr_r) begin
                    if (tk_r < 5'(v_r ? BDL_HOST_ONE_LOW_TICKS : BDL_HOST_ZERO_LOW_TICKS)) begin
                        oe_nxt = 1'b1;
                        o_nxt = 1'b0;
                    end else if (tk_r == 5'(v_r ? BDL_HOST_ONE_LOW_TICKS
                                                : BDL_HOST_ZERO_LOW_TICKS)) begin
                        oe_nxt = 1'b1;
                    end
                end else if (tk_r < 5'(BDL_HOST_LOW_TICKS)) begin
                    oe_nxt = 1'b1;
                    o_nxt = 1'b0;
                end
                if (tick) begin
                    tk_nxt = tk_r + 1'b1;
                    if (!wr_r && tk_r == 5'(BDL_SAMPLE_TICK)) begin
                        rx_nxt = s2_r;
                    end
                    if (tk_r == 5'(BDL_BIT_TICKS)) begin
                        st_nxt = BDH_IDLE;
                        done_nxt = 1'b1;
                    end
                end
            end
            default: st_nxt = BDH_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= BDH_IDLE;
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            div_r <= '0;
            tk_r <= '0;
            wr_r <= 1'b0;
            v_r <= 1'b0;
            oe_r <= 1'b0;
            o_r <= 1'b1;
            rx_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            s1_r <= link.debug_serial_pin;
            s2_r <= s1_r;
            div_r <= div_nxt;
            tk_r <= tk_nxt;
            wr_r <= wr_nxt;
            v_r <= v_nxt;
            oe_r <= oe_nxt;
            o_r <= o_nxt;
            rx_r <= rx_nxt;
            done_r <= done_nxt;
        end
    end
    assign link.host_oe = oe_r;
    assign link.host_o = o_r;
    assign bit_ready_o = st_r == BDH_IDLE;
    assign bit_done_o = done_r;
    assign bit_rx_o = rx_r;
endmodule // bdl_host

// >>> testbench/bdl_link_assertions.sv
module bdl_link_assertions (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic serial_clock_select_i,
    input wire logic dev_oe,
    input wire logic dev_o,
    input wire logic host_oe,
    input wire logic host_o,
    input wire logic debug_serial_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dev_lo, dev_hi, host_lo, host_hi, pin_r;
    logic [10:0] since_r, since_nxt, drun_r, drun_nxt, hrun_r, hrun_nxt;
    assign dev_lo = dev_oe && !dev_o;
    assign dev_hi = dev_oe && dev_o;
    assign host_lo = host_oe && !host_o;
    assign host_hi = host_oe && host_o;
    // cycles since the last pin fall and length of each low drive
    always_comb begin
        since_nxt = since_r + {10'h000, since_r != 11'h7ff};
        if (pin_r && !debug_serial_pin) begin
            since_nxt = 11'h001;
        end
        drun_nxt = dev_lo ? drun_r + 11'h001 : 11'h000;
        hrun_nxt = host_lo ? hrun_r + 11'h001 : 11'h000;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_r <= 11'h7ff;
            drun_r <= 11'h000;
            hrun_r <= 11'h000;
            pin_r <= 1'b1;
        end else begin
            since_r <= since_nxt;
            drun_r <= drun_nxt;
            hrun_r <= hrun_nxt;
            pin_r <= debug_serial_pin;
        end
    end
    // timing is checked at the fast rate only: one tick is two clocks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i || !serial_clock_select_i);
    sequence s_one_tick(x);
        x ##1 x ##1 !x;
    endsequence
    a_dev_speedup_len: assert property ($rose(dev_hi) |-> s_one_tick(dev_hi))
        else $error("device speedup not one tick");
    a_host_speedup_len: assert property ($rose(host_hi) |-> s_one_tick(host_hi))
        else $error("host speedup not one tick");
    a_low_then_speedup: assert property ($fell(dev_lo) |-> dev_hi)
        else $error("device low drive not closed by speedup");
    a_one_speedup_time: assert property ($rose(dev_hi) && !$past(dev_lo) |->
        since_r inside {[14:22]}) else $error("returned one speedup mistimed");
    a_zero_ack_len: assert property ($fell(dev_lo) |-> drun_r inside {[30:34]} ||
        (drun_r inside {[18:28]} && since_r inside {[26:34]}))
        else $error("device low drive has wrong length");
    a_host_low_min: assert property ($rose(host_lo) |-> host_lo [*4])
        else $error("host low shorter than two ticks");
    a_host_tx_len: assert property ($fell(host_lo) && host_hi |-> hrun_r == 11'd9 ||
        hrun_r == 11'd27) else $error("host transmit low length wrong");
    a_no_conflict: assert property (dev_hi || host_hi |-> !(dev_lo || host_lo))
        else $error("speedup against a low drive");
    c_ack_seen: cover property (drun_r == 11'd31);
endmodule // bdl_link_assertions

// >>> testbench/test_background_debug_bit_link.sv
module test_background_debug_bit_link;
    import bdl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic clk_sel = 1'b1;
    logic rx_ready = 1'b0;
    logic tx_valid = 1'b0;
    logic ack_req = 1'b0;
    logic b_start = 1'b0;
    logic b_write = 1'b0;
    logic b_val = 1'b0;
    logic dev_hold = 1'b0;
    logic [15:0] tx_data = 16'h0000;
    logic [15:0] rx_data, w;
    logic mode_sel, rx_valid, rx_is_op, tx_ready, ack_busy, tmo, b_ready, b_done, b_rx;
    int bad_count = 0;
    int check_count = 0;
    int n;
    bdl_link_if link ();
    bdl_device bdl_device_inst (.clk_i(clk_i), .rstn_i(rstn_i && !dev_hold), .link(link.device),
        .serial_clock_select_i(clk_sel), .mode_select_o(mode_sel), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .rx_data_o(rx_data), .rx_is_opcode_o(rx_is_op),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data),
        .ack_req_i(ack_req), .ack_busy_o(ack_busy), .timeout_o(tmo));
    bdl_host bdl_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link.host),
        .serial_clock_select_i(clk_sel), .bit_start_i(b_start), .bit_write_i(b_write),
        .bit_val_i(b_val), .bit_ready_o(b_ready), .bit_done_o(b_done), .bit_rx_o(b_rx));
    bdl_link_assertions bdl_link_assertions_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .serial_clock_select_i(clk_sel), .dev_oe(link.dev_oe), .dev_o(link.dev_o),
        .host_oe(link.host_oe), .host_o(link.host_o),
        .debug_serial_pin(link.debug_serial_pin));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_lv(ref logic s, input logic lv, input int lim);
        int k;
        k = 0;
        while (s !== lv && k < lim) begin
            @(negedge clk_i);
            k++;
        end
        check(16'(k < lim), 16'h0001);
    endtask
    task automatic xfer_bit(input logic wr, input logic v, output logic r);
        wait_lv(b_ready, 1'b1, 300);
        b_start = 1'b1;
        b_write = wr;
        b_val = v;
        @(negedge clk_i);
        wait_lv(b_done, 1'b1, 300);
        r = b_rx;
        b_start = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic send(input logic [15:0] v, input int bits);
        logic r;
        for (int i = bits - 1; i >= 0; i--) begin
            xfer_bit(1'b1, v[i], r);
        end
    endtask
    task automatic pop(input logic [15:0] exp, input logic op);
        wait_lv(rx_valid, 1'b1, 100);
        check(op ? {8'h00, rx_data[7:0]} : rx_data, exp);
        rx_ready = 1'b1;
        @(negedge clk_i);
        rx_ready = 1'b0;
    endtask
    // idle past the inactivity timeout, then drop whatever was left queued
    task automatic gap;
        repeat (clk_sel ? 1100 : 4300) @(negedge clk_i);
        rx_ready = 1'b1;
        repeat (20) @(negedge clk_i);
        rx_ready = 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (60000) @(negedge clk_i);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(16'(mode_sel), 16'h0001);
        send(16'h00a5, BDL_OPCODE_BITS);
        send(16'h1234, BDL_WORD_BITS);
        check(16'(rx_is_op), 16'h0000);
        repeat (BDL_FW_WRITE_WAIT_BUS) @(negedge clk_i);
        pop(16'h00a5, 1'b1);
        pop(16'h1234, 1'b0);
        tx_data = 16'hc3a5;
        tx_valid = 1'b1;
        wait_lv(tx_ready, 1'b1, 100);
        @(negedge clk_i);
        tx_valid = 1'b0;
        for (int i = 0; i < BDL_WORD_BITS; i++) begin
            xfer_bit(1'b0, 1'b0, w[15 - i]);
        end
        check(w, 16'hc3a5);
        ack_req = 1'b1;
        @(negedge clk_i);
        ack_req = 1'b0;
        @(negedge clk_i);
        check(16'(ack_busy), 16'h0001);
        wait_lv(ack_busy, 1'b0, 100);
        gap();
        send(16'h0005, 3);
        n = 0;
        while (tmo !== 1'b1 && n < 1200) begin
            @(negedge clk_i);
            n++;
        end
        check(16'(n > 959 && n < 1061), 16'h0001);
        send(16'h003c, BDL_OPCODE_BITS);
        check(16'(rx_is_op), 16'h0001);
        pop(16'h003c, 1'b1);
        gap();
        clk_sel = 1'b0;
        repeat (20) @(negedge clk_i);
        send(16'h0081, BDL_OPCODE_BITS);
        repeat (BDL_STEP_GO_WAIT_BUS) @(negedge clk_i);
        pop(16'h0081, 1'b1);
        gap();
        clk_sel = 1'b1;
        gap();
        send(16'h0042, BDL_OPCODE_BITS);
        for (int i = 0; i < BDL_FIFO_DEPTH; i++) begin
            send(16'h1000 + 16'(i), BDL_WORD_BITS);
        end
        pop(16'h0042, 1'b1);
        for (int i = 0; i < BDL_FIFO_DEPTH - 1; i++) begin
            pop(16'h1000 + 16'(i), 1'b0);
        end
        @(negedge clk_i);
        check(16'(rx_valid), 16'h0000);
        // device alone is reset while the host holds the pin low
        fork
            xfer_bit(1'b1, 1'b0, w[0]);
            begin
                wait (link.host_oe === 1'b1);
                @(negedge clk_i);
                dev_hold = 1'b1;
                repeat (4) @(negedge clk_i);
                dev_hold = 1'b0;
                repeat (2) @(negedge clk_i);
                check(16'(mode_sel), 16'h0000);
            end
        join
        check(16'(mode_sel), 16'h0000);
        wrap_up();
    end
endmodule // test_background_debug_bit_link
